// *** drc_run_control.v ***
// What this block does
// - halt request bit 2 forces the core into halted debug state
// - halt request wakes a sleeping core from stop or wait, then halts
// - system reset request bit 3 holds system reset while set
// - core hold bit 4 clear releases core with system after sequencing
// - core hold set keeps core in reset; clearing releases at once
// - hold request bit 5 holds system in reset after next stop recovery
// - hold request ignored on reset-pin wakeup; pin alone holds reset
// - hold request latched on stop entry; exit held until release ack
// - hold request cleared by power-on reset of stop recovery
// - release ack bit 6 releases system held after stop recovery
// - release ack cleared by debugger or by next recovery power-on reset
// - writing 1 to bit 7 clears sticky stop entry status flags
// - bits 8 to 31 reserved with no effect
// - in secure state only system reset request takes effect
// - register reached only through the debug access port
`timescale 1ns/100ps
`include "drc_defines.vh"
module drc_run_control (
	input wire clock,
	input wire srst,
	input wire por,
	input wire ap_wr,
	input wire ap_rd,
	input wire ap_sel,
	input wire [31:0] ap_wdata,
	output reg [31:0] ap_rdata,
	output reg ap_rvalid,
	input wire flash_secure,
	input wire core_sleeping,
	input wire core_halted,
	input wire reset_seq_done,
	input wire reset_pin_n,
	input wire vlls_entry,
	input wire vlls_exit,
	input wire low_leak_stop_entry,
	output reg core_halt_req,
	output reg core_wake_req,
	output reg sys_reset_req,
	output reg core_reset_hold,
	output reg vlls_reset_hold
);
// =============================================
// state codes for the stop-recovery sequencer
localparam ST_RUN = 2'b00;
localparam ST_STOPPED = 2'b01;
localparam ST_HELD = 2'b10;
localparam ST_PIN = 2'b11;

// =============================================
// pin input synchronisers
wire [3:0] sync_w;
drc_sync #(
	.WIDTH(4)
) u_sync (
	.clock(clock),
	.srst(srst),
	.async_in({reset_pin_n, core_sleeping, core_halted, flash_secure}),
	.sync_out(sync_w)
);
wire pin_n_s = sync_w[3];
wire sleeping_s = sync_w[2];
wire halted_s = sync_w[1];
wire secure_s = sync_w[0];

function effective;
	input bit_in;
	input secure_capable;
	input secure;
	begin
		effective = bit_in & (secure_capable | ~secure);
	end
endfunction

// =============================================
// control register
reg [31:0] ctrl_r;
reg [31:0] ctrl_nxt;
reg low_leak_flag_r;
reg vlls_flag_r;
reg hold_latched_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg core_held_r;

// access port
// only the debug access port writes this register, but por also clears bits 5 and 6; no system bus path exists
always @* begin
	ctrl_nxt = ctrl_r;
	if (ap_wr && ap_sel == `DRC_SEL_CONTROL) begin
		ctrl_nxt = ap_wdata & `DRC_CTRL_WMASK;
	end
	if (por) begin
		ctrl_nxt[`DRC_BIT_HOLD_REQ] = 1'b0;
		ctrl_nxt[`DRC_BIT_RELEASE_ACK] = 1'b0;
	end
end

always @(posedge clock) begin
	if (srst) begin
		ctrl_r <= `DRC_CTRL_RESET;
	end else begin
		ctrl_r <= ctrl_nxt;
	end
end

wire halt_eff = effective(ctrl_r[`DRC_BIT_HALT_REQ], 1'b0, secure_s);
wire rst_eff = effective(ctrl_r[`DRC_BIT_SYS_RST_REQ], 1'b1, secure_s);
wire hold_eff = effective(ctrl_r[`DRC_BIT_CORE_HOLD], 1'b0, secure_s);
wire hreq_eff = effective(ctrl_r[`DRC_BIT_HOLD_REQ], 1'b0, secure_s);
wire ack_eff = effective(ctrl_r[`DRC_BIT_RELEASE_ACK], 1'b0, secure_s);
wire sack_eff = effective(ctrl_r[`DRC_BIT_STATUS_ACK], 1'b0, secure_s);

// =============================================
// sticky stop entry status
always @(posedge clock) begin
	if (srst) begin
		low_leak_flag_r <= 1'b0;
		vlls_flag_r <= 1'b0;
	end else begin
		// ack clears flags
		// a new entry in the ack cycle still sets the flag
		low_leak_flag_r <= low_leak_stop_entry | (low_leak_flag_r & ~sack_eff);
		vlls_flag_r <= vlls_entry | (vlls_flag_r & ~sack_eff);
	end
end

// =============================================
// stop recovery sequencer
always @* begin
	state_nxt = state_r;
	case (state_r)
		ST_RUN: begin
			if (vlls_entry) begin
				state_nxt = ST_STOPPED;
			end
		end
		ST_STOPPED: begin
			if (vlls_exit) begin
				if (!pin_n_s) begin
					state_nxt = ST_PIN;
				end else if (hold_latched_r) begin
					state_nxt = ST_HELD;
				end else begin
					state_nxt = ST_RUN;
				end
			end
		end
		ST_HELD: begin
			if (ack_eff) begin
				state_nxt = ST_RUN;
			end
		end
		ST_PIN: begin
			if (pin_n_s) begin
				state_nxt = ST_RUN;
			end
		end
		default: begin
			state_nxt = ST_RUN;
		end
	endcase
end

always @(posedge clock) begin
	if (srst) begin
		state_r <= ST_RUN;
		hold_latched_r <= 1'b0;
	end else begin
		state_r <= state_nxt;
		if (state_r == ST_RUN && vlls_entry) begin
			hold_latched_r <= hreq_eff;
		end
	end
end

// =============================================
// core hold after reset sequencing
// the held state is entered only when sequencing ends with the hold bit set
reg core_held_nxt;
always @* begin
	core_held_nxt = core_held_r;
	if (sys_reset_req) begin
		core_held_nxt = 1'b0;
	end else if (reset_seq_done && hold_eff) begin
		core_held_nxt = 1'b1;
	end else if (!hold_eff) begin
		core_held_nxt = 1'b0;
	end
end

always @(posedge clock) begin
	if (srst) begin
		core_held_r <= 1'b0;
	end else begin
		core_held_r <= core_held_nxt;
	end
end

// =============================================
// core hold output
// hold only while the bit stays set; clearing it frees the core on the next edge
always @(posedge clock) begin
	if (srst) begin
		core_reset_hold <= 1'b0;
	end else begin
		core_reset_hold <= hold_eff & ~sys_reset_req & (core_held_r | reset_seq_done);
	end
end

// =============================================
// halt and wake requests
always @(posedge clock) begin
	if (srst) begin
		core_halt_req <= 1'b0;
		core_wake_req <= 1'b0;
	end else begin
		core_halt_req <= halt_eff;
		// wake sleeping core
		// a sleeping core must be woken before it can reach the halted state
		core_wake_req <= halt_eff & sleeping_s;
	end
end

// =============================================
// system reset request
always @(posedge clock) begin
	if (srst) begin
		sys_reset_req <= 1'b0;
	end else begin
		sys_reset_req <= rst_eff;
	end
end

// =============================================
// stop recovery hold
always @(posedge clock) begin
	if (srst) begin
		vlls_reset_hold <= 1'b0;
	end else begin
		// hold after recovery
		// taken from the next state so the hold starts with the exit edge
		vlls_reset_hold <= (state_nxt == ST_HELD);
	end
end

// =============================================
// status view
// bits not listed here read zero
reg [31:0] status_nxt;
always @* begin
	status_nxt = `DRC_STAT_RESET;
	status_nxt[`DRC_ST_SYS_OUT_OF_RST] = ~sys_reset_req;
	status_nxt[`DRC_ST_LOW_LEAK_ENTERED] = low_leak_flag_r;
	status_nxt[`DRC_ST_VLLS_ENTERED] = vlls_flag_r;
	status_nxt[`DRC_ST_CORE_HALTED] = halted_s;
	status_nxt[`DRC_ST_CORE_HELD] = core_held_r;
	status_nxt[`DRC_ST_VLLS_HELD] = (state_r == ST_HELD);
end

// =============================================
// read port, one cycle after the read strobe
reg [31:0] rdata_nxt;
always @* begin
	rdata_nxt = ap_rdata;
	if (ap_rd) begin
		if (ap_sel == `DRC_SEL_CONTROL) begin
			rdata_nxt = ctrl_r & `DRC_CTRL_WMASK;
		end else begin
			rdata_nxt = status_nxt;
		end
	end
end

// read data holds until the next read so a slow debugger may pick it up late
always @(posedge clock) begin
	if (srst) begin
		ap_rdata <= 32'h0000_0000;
		ap_rvalid <= 1'b0;
	end else begin
		ap_rvalid <= ap_rd;
		ap_rdata <= rdata_nxt;
	end
end
endmodule

// *** drc_defines.vh ***
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH
// =============================================
// register select and layout
`define DRC_SEL_CONTROL 1'b1
`define DRC_SEL_STATUS 1'b0
`define DRC_BIT_HALT_REQ 2
`define DRC_BIT_SYS_RST_REQ 3
`define DRC_BIT_CORE_HOLD 4
`define DRC_BIT_HOLD_REQ 5
`define DRC_BIT_RELEASE_ACK 6
`define DRC_BIT_STATUS_ACK 7
`define DRC_CTRL_RESET 32'h0000_0000
`define DRC_CTRL_WMASK 32'h0000_00FC
`define DRC_STAT_RESET 32'h0000_0000
// status readback bit positions
`define DRC_ST_SYS_OUT_OF_RST 3
`define DRC_ST_LOW_LEAK_ENTERED 5
`define DRC_ST_VLLS_ENTERED 6
`define DRC_ST_CORE_HALTED 16
`define DRC_ST_CORE_HELD 17
`define DRC_ST_VLLS_HELD 18
`endif

// *** drc_sync.v ***
`timescale 1ns/100ps
`include "drc_defines.vh"
module drc_sync #(
	parameter WIDTH = 4
) (
	input wire clock,
	input wire srst,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
// =============================================
// two-stage synchroniser; first stage read only here
reg [WIDTH-1:0] meta_r;
always @(posedge clock) begin
	if (srst) begin
		meta_r <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end else begin
		meta_r <= async_in;
		sync_out <= meta_r;
	end
end
endmodule

// *** drc_chk_sva.sv ***
`timescale 1ns/100ps
// ====
// checks
module drc_chk (
	input clock,
	input srst,
	input por,
	input ap_wr,
	input ap_rd,
	input ap_sel,
	input [31:0] ap_wdata,
	input [31:0] ap_rdata,
	input ap_rvalid,
	input flash_secure,
	input reset_pin_n,
	input vlls_exit,
	input core_halt_req,
	input sys_reset_req,
	input core_reset_hold,
	input vlls_reset_hold
);
	wire w = ap_wr && ap_sel;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// inputs pass two flops, so the level must stand a while
	sequence s_sec; flash_secure [*4]; endsequence
	sequence s_pin; !reset_pin_n [*3]; endsequence
	a_read_answer: assert property (ap_rd && ap_sel |=> ap_rvalid && ap_rdata[31:8] == 24'h00_0000)
		else $error("read answer");
	a_sys_reset: assert property (w && ap_wdata[3] |-> ##2 sys_reset_req)
		else $error("sys reset");
	a_halt_off: assert property (w && !ap_wdata[2] |-> ##2 !core_halt_req)
		else $error("halt off");
	a_core_free: assert property (w && !ap_wdata[4] |-> ##2 !core_reset_hold)
		else $error("core free");
	a_secure_gate: assert property (s_sec |-> !core_halt_req)
		else $error("secure gate");
	a_hold_kept: assert property (vlls_reset_hold && !ap_wr && !$past(ap_wr) && !por |=> vlls_reset_hold)
		else $error("hold kept");
	a_ack_free: assert property (w && ap_wdata[6] && !por && vlls_reset_hold |-> ##2 !vlls_reset_hold)
		else $error("ack free");
	a_pin_wake: assert property (s_pin ##0 vlls_exit |=> !vlls_reset_hold)
		else $error("pin wake");
endmodule
bind drc_run_control drc_chk chk_i (.*);

// *** drc_dbg_model.sv ***
`timescale 1ns/100ps
// ====
// debugger model
module drc_dbg_model (
	input clock,
	output reg ap_wr,
	output reg ap_rd,
	output reg ap_sel,
	output reg [31:0] ap_wdata,
	input [31:0] ap_rdata,
	input ap_rvalid
);
	initial begin
		{ap_wr, ap_rd, ap_sel} = 3'h0;
		ap_wdata = 32'h0000_0000;
	end
	task wr(input s, input [31:0] v);
		@(posedge clock);
		#1 {ap_wr, ap_sel, ap_wdata} = {1'b1, s, v};
		@(posedge clock);
		#1 {ap_wr, ap_wdata} = {1'b0, ~v};
		@(posedge clock);
		#1;
	endtask
	task rd(input s, output [31:0] v);
		@(posedge clock);
		#1 {ap_rd, ap_sel} = {1'b1, s};
		@(posedge clock);
		#1 ap_rd = 1'b0;
		v = ap_rvalid ? ap_rdata : ~ap_rdata;
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
// ====
// bench
module tb_top;
	reg clock, srst, flash_secure, core_sleeping, core_halted, reset_seq_done, reset_pin_n;
	reg por, vlls_entry, vlls_exit, low_leak_stop_entry;
	reg [31:0] d;
	integer mismatches, tests_run;
	wire ap_wr, ap_rd, ap_sel, ap_rvalid, core_halt_req, core_wake_req, sys_reset_req, core_reset_hold;
	wire vlls_reset_hold;
	wire [31:0] ap_wdata, ap_rdata;
	drc_run_control dut (.*);
	drc_dbg_model dbg (.*);
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task chk(input [31:0] g, input [31:0] e);
		tests_run = tests_run + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task pulse(input [3:0] m);
		@(posedge clock);
		#1 {por, vlls_entry, vlls_exit, low_leak_stop_entry} = m;
		@(posedge clock);
		#1 {por, vlls_entry, vlls_exit, low_leak_stop_entry} = 4'h0;
	endtask
	task results;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task t_bits;
		dbg.rd(1'b1, d);
		chk(d, 32'h0000_0000);
		core_sleeping = 1'b1;
		dbg.wr(1'b1, 32'hFFFF_FF1F);
		dbg.rd(1'b1, d);
		chk(d, 32'h0000_001C);
		chk({core_halt_req, core_wake_req, sys_reset_req}, 3'h7);
		dbg.wr(1'b1, 32'h0000_0000);
		chk({core_halt_req, core_wake_req, sys_reset_req}, 3'h0);
		core_sleeping = 1'b0;
		reset_seq_done = 1'b1;
		dbg.wr(1'b1, 32'h0000_0010);
		chk(core_reset_hold, 1);
		dbg.wr(1'b1, 32'h0000_0000);
		chk(core_reset_hold, 0);
		flash_secure = 1'b1;
		dbg.wr(1'b1, 32'h0000_000C);
		chk({core_halt_req, sys_reset_req}, 2'h1);
		dbg.wr(1'b1, 32'h0000_0000);
		flash_secure = 1'b0;
		$display("bits test end");
	endtask
	task t_stop;
		dbg.wr(1'b1, 32'h0000_0020);
		pulse(4'h4);
		pulse(4'h8);
		dbg.rd(1'b1, d);
		chk(d, 32'h0000_0000);
		pulse(4'h2);
		repeat (4) @(posedge clock);
		chk(vlls_reset_hold, 1);
		dbg.wr(1'b1, 32'h0000_0040);
		chk(vlls_reset_hold, 0);
		pulse(4'h8);
		dbg.rd(1'b1, d);
		chk(d, 32'h0000_0000);
		dbg.wr(1'b1, 32'h0000_0020);
		pulse(4'h4);
		reset_pin_n = 1'b0;
		pulse(4'h8);
		pulse(4'h2);
		chk(vlls_reset_hold, 0);
		reset_pin_n = 1'b1;
		$display("stop test end");
	endtask
	task t_status;
		core_halted = 1'b1;
		pulse(4'h1);
		dbg.rd(1'b0, d);
		chk({d[16], d[5]}, 2'h3);
		dbg.wr(1'b1, 32'h0000_0080);
		dbg.rd(1'b0, d);
		chk(d[6:5], 2'h0);
		dbg.rd(1'b1, d);
		chk(d, 32'h0000_0080);
		dbg.wr(1'b1, 32'h0000_0000);
		$display("status test end");
	endtask
	initial begin
		{srst, flash_secure, core_sleeping, core_halted, reset_seq_done} = 5'h10;
		{reset_pin_n, por, vlls_entry, vlls_exit, low_leak_stop_entry} = 5'h10;
		mismatches = 0;
		tests_run = 0;
		repeat (20) @(posedge clock);
		#1 srst = 1'b0;
		t_bits;
		t_stop;
		t_status;
		results;
	end
	initial begin
		#500000;
		mismatches = mismatches + 1;
		results;
	end
endmodule
